// [hw/i2chcb_pkg.sv]
package i2chcb_pkg;
   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int unsigned AW = 8;
   localparam logic [7:0] OFS_ENABLE  = 8'h00;
   localparam logic [7:0] OFS_CMDCTRL = 8'h04;
   localparam logic [7:0] OFS_BAUD    = 8'h0c;
   localparam logic [7:0] OFS_IENCLR  = 8'h14;
   localparam logic [7:0] OFS_IENSET  = 8'h18;
   localparam logic [7:0] OFS_FLAGS   = 8'h1c;
   localparam logic [7:0] OFS_STATUS  = 8'h20;
   localparam logic [7:0] OFS_ADDR    = 8'h24;
   localparam logic [7:0] OFS_DATA    = 8'h28;
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int unsigned EN_BIT    = 1;
   localparam int unsigned CC_AUTO_ACK_ON_READ_ENABLE   = 8;
   localparam int unsigned CC_QUICK_CMD_ENABLE   = 9;
   localparam int unsigned CC_CMD_LO = 16;
   localparam int unsigned CC_CMD_HI = 17;
   localparam int unsigned CC_ACK    = 18;
   localparam int unsigned BD_LOW_LO = 8;
   localparam int unsigned BD_LOW_HI = 15;
   localparam int unsigned IE_MB     = 0;
   localparam int unsigned IE_SB     = 1;
   localparam int unsigned IE_ERR    = 7;
   localparam int unsigned FL_MB     = 0;
   localparam int unsigned FL_SB     = 1;
   localparam int unsigned ST_SYSTEM_OP_BUSY  = 0;
   localparam int unsigned ST_HOLD   = 1;
   localparam logic [7:0]  IE_MASK   = 8'h83;
   localparam logic [7:0]  BAUD_RST  = 8'h00;
   localparam logic [7:0]  IE_RST    = 8'h00;
   // ------------------------------------------------------------------
   // commands, operations, responses
   // ------------------------------------------------------------------
   localparam logic [1:0] CMD_NONE   = 2'h0;
   localparam logic [1:0] CMD_RSTART = 2'h1;
   localparam logic [1:0] CMD_READ   = 2'h2;
   localparam logic [1:0] CMD_STOP   = 2'h3;
   localparam logic [2:0] OP_IDLE       = 3'h0;
   localparam logic [2:0] OP_ACK_RSTART = 3'h1;
   localparam logic [2:0] OP_ACK_READ   = 3'h2;
   localparam logic [2:0] OP_ACK_STOP   = 3'h3;
   localparam logic [2:0] OP_NEW_ADDR   = 3'h4;
   localparam logic [2:0] OP_SEND_BYTE  = 3'h5;
   localparam logic [2:0] OP_ACK_ONLY   = 3'h6;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/i2chcb_top.sv]
// Summary of operation
// RULE1: ack select 0 sends ACK, 1 sends NACK after a received byte.
// RULE2: command field write starts an operation; it always reads zero.
// RULE3: ack action applies only when reading; writing gives restart or stop.
// RULE4: ack select written with a command is updated before the command.
// RULE5: commands are taken only while a bus flag is set.
// RULE6: command 0x1 does ack action, repeated start, then current address.
// RULE7: writing the address register does a repeated start with new address.
// RULE8: every command sets the system-operation busy bit until done.
// RULE9: 0x0 nothing; 0x2 reads a byte when reading; 0x3 ack then stop.
// RULE10: smart mode sends the ack action on a data register read.
// RULE11: quick-command bit enables quick-command operation.
// RULE12: non-zero low field sets the SCL low period.
// RULE13: baud field sets high period, and low too when low field is zero.
// RULE14: writing one to an enable-clear bit disables that interrupt.
// RULE15: enable-set and enable-clear share one enable state.
// RULE16: control and baud are write-protected while enabled, except cmd/ack.
// RULE17: protected writes while enabled are ignored, values unchanged.
// RULE18: client flag set on received byte; SCL held low while set.
// RULE19: host flag set per sent byte; SCL held unless arbitration lost.
// RULE20: address, data write, smart read or valid command release the hold.
`timescale 1ns/1ps
module i2chcb_top (
   // clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   // axi4-lite write address and data
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        WVALID,
   output logic             WREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   // axi4-lite write response
   output logic             BVALID,
   input  wire logic        BREADY,
   output logic [1:0]       BRESP,
   // axi4-lite read
   input  wire logic        ARVALID,
   output logic             ARREADY,
   input  wire logic [7:0]  ARADDR,
   output logic             RVALID,
   input  wire logic        RREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   // bus engine events
   input  wire logic        BYTE_RECEIVED,
   input  wire logic        BYTE_SENT,
   input  wire logic        ARB_LOST,
   input  wire logic        HOST_READING,
   input  wire logic        OP_DONE,
   input  wire logic [7:0]  RX_DATA,
   // operation request to the bus engine
   output logic             OP_START,
   output logic [2:0]       OP_KIND,
   output logic             OP_ACK_NACK,
   output logic             OP_ACK_APPLY,
   output logic [7:0]       TX_ADDR,
   output logic [7:0]       TX_DATA,
   // configuration to the bus engine
   output logic             SCL_HOLD,
   output logic [7:0]       SCL_HIGH_PERIOD,
   output logic [7:0]       SCL_LOW_PERIOD,
   output logic             QUICK_CMD_EN,
   output logic             PERIPH_ENABLE,
   output logic [7:0]       INT_ENABLE
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic lane_on(input logic [3:0] strb,
                                    input int unsigned bitpos);
      lane_on = strb[bitpos / 8];
   endfunction

   // ------------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------------
   logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] wr_data_r, rdata_r;
   logic [3:0]  wr_strb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_nxt;
   logic        rd_hit;

   wire wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   wire rd_fire = ARVALID & ~rvalid_r;
   wire wr_hit  = wr_hit_f(wr_addr_r);

   assign AWREADY = ~aw_have_r & ~bvalid_r;
   assign WREADY  = ~w_have_r & ~bvalid_r;
   assign ARREADY = ~rvalid_r;
   assign BVALID  = bvalid_r;
   assign BRESP   = bresp_r;
   assign RVALID  = rvalid_r;
   assign RDATA   = rdata_r;
   assign RRESP   = rresp_r;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= i2chcb_pkg::RESP_OKAY;
         wr_addr_r <= 8'h00;
         wr_data_r <= 32'h0000_0000;
         wr_strb_r <= 4'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_have_r <= 1'b1;
            wr_addr_r <= {AWADDR[7:2], 2'b00};
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (WVALID && WREADY) begin
            w_have_r  <= 1'b1;
            wr_data_r <= WDATA;
            wr_strb_r <= WSTRB;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? i2chcb_pkg::RESP_OKAY
                               : i2chcb_pkg::RESP_SLVERR;
         end else if (BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= i2chcb_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rd_hit ? i2chcb_pkg::RESP_OKAY
                            : i2chcb_pkg::RESP_SLVERR;
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   logic       enable_r, auto_ack_on_read_enable_r, quick_cmd_enable_r, ack_r, mb_r, sb_r, arb_r;
   logic       system_op_busy_r, hold_r;
   logic [7:0] baud_r, baud_low_r, ien_r, addr_r, txd_r;

   wire w_en  = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_ENABLE)
              & lane_on(wr_strb_r, i2chcb_pkg::EN_BIT);
   wire w_ccl = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_CMDCTRL)
              & lane_on(wr_strb_r, i2chcb_pkg::CC_AUTO_ACK_ON_READ_ENABLE);
   wire w_cch = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_CMDCTRL)
              & lane_on(wr_strb_r, i2chcb_pkg::CC_ACK);
   wire w_bdh = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_BAUD)
              & lane_on(wr_strb_r, 0);
   wire w_bdl = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_BAUD)
              & lane_on(wr_strb_r, i2chcb_pkg::BD_LOW_LO);
   wire w_iec = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_IENCLR)
              & lane_on(wr_strb_r, 0);
   wire w_ies = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_IENSET)
              & lane_on(wr_strb_r, 0);
   wire w_flg = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_FLAGS)
              & lane_on(wr_strb_r, 0);
   wire w_adr = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_ADDR)
              & lane_on(wr_strb_r, 0);
   wire w_dat = wr_fire & (wr_addr_r == i2chcb_pkg::OFS_DATA)
              & lane_on(wr_strb_r, 0);
   wire [7:0] wb0 = wr_data_r[7:0];
   wire [7:0] wb1 = wr_data_r[15:8];

   // protected fields move only while disabled
   wire prot_ok = ~enable_r;                                   // [RULE16]
   wire cfg_wr  = w_ccl & prot_ok;                             // [RULE17]

   // ------------------------------------------------------------------
   // command decode and issue
   // ------------------------------------------------------------------
   wire [1:0] cmd_val = wr_data_r[i2chcb_pkg::CC_CMD_HI:
                                  i2chcb_pkg::CC_CMD_LO];
   wire flag_any = mb_r | sb_r;
   wire cmd_wr   = w_cch & (cmd_val != i2chcb_pkg::CMD_NONE);   // [RULE2]
   wire read_nop = (cmd_val == i2chcb_pkg::CMD_READ) & ~HOST_READING;
   wire cmd_ok   = cmd_wr & flag_any & ~read_nop;      // [RULE5] [RULE9]
   wire smart_rd = rd_fire & auto_ack_on_read_enable_r & flag_any
                 & ({ARADDR[7:2], 2'b00} == i2chcb_pkg::OFS_DATA);
   wire release_ev = w_adr | w_dat | smart_rd | cmd_ok;        // [RULE20]
   // the ack bit of the same write is the one the command uses
   wire ack_nxt = w_cch ? wr_data_r[i2chcb_pkg::CC_ACK] : ack_r; // [RULE4]
   logic [2:0] kind_nxt;

   always_comb begin
      kind_nxt = i2chcb_pkg::OP_IDLE;
      if (w_adr) begin
         kind_nxt = i2chcb_pkg::OP_NEW_ADDR;                   // [RULE7]
      end else if (w_dat) begin
         kind_nxt = i2chcb_pkg::OP_SEND_BYTE;
      end else if (cmd_ok) begin
         case (cmd_val)
            i2chcb_pkg::CMD_RSTART: kind_nxt = i2chcb_pkg::OP_ACK_RSTART;
            i2chcb_pkg::CMD_READ:   kind_nxt = i2chcb_pkg::OP_ACK_READ;
            i2chcb_pkg::CMD_STOP:   kind_nxt = i2chcb_pkg::OP_ACK_STOP;
            default:                kind_nxt = i2chcb_pkg::OP_IDLE;
         endcase                                        // [RULE6] [RULE9]
      end else if (smart_rd) begin
         kind_nxt = i2chcb_pkg::OP_ACK_ONLY;                   // [RULE10]
      end
   end

   // ------------------------------------------------------------------
   // flags, busy and clock hold (set wins over clear)
   // ------------------------------------------------------------------
   wire mb_nxt = BYTE_SENT | (mb_r & ~release_ev
               & ~(w_flg & wb0[i2chcb_pkg::FL_MB]));           // [RULE19]
   wire sb_nxt = BYTE_RECEIVED | (sb_r & ~release_ev
               & ~(w_flg & wb0[i2chcb_pkg::FL_SB]));           // [RULE18]
   wire arb_nxt = BYTE_SENT ? ARB_LOST : arb_r;
   wire hold_nxt = (mb_nxt & ~arb_nxt) | sb_nxt;        // [RULE18] [RULE19]
   wire system_op_busy_nxt = release_ev | (system_op_busy_r & ~OP_DONE);         // [RULE8]
   wire [7:0] ien_nxt = ((ien_r & ~(w_iec ? wb0 : 8'h00))
                      | (w_ies ? wb0 : 8'h00))
                      & i2chcb_pkg::IE_MASK;         // [RULE14] [RULE15]

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         enable_r   <= 1'b0;
         auto_ack_on_read_enable_r     <= 1'b0;
         quick_cmd_enable_r     <= 1'b0;
         ack_r      <= 1'b0;
         baud_r     <= i2chcb_pkg::BAUD_RST;
         baud_low_r <= i2chcb_pkg::BAUD_RST;
         ien_r      <= i2chcb_pkg::IE_RST;
         mb_r       <= 1'b0;
         sb_r       <= 1'b0;
         arb_r      <= 1'b0;
         hold_r     <= 1'b0;
         system_op_busy_r    <= 1'b0;
      end else begin
         if (w_en) enable_r <= wb0[i2chcb_pkg::EN_BIT];
         if (cfg_wr) begin
            auto_ack_on_read_enable_r <= wb1[i2chcb_pkg::CC_AUTO_ACK_ON_READ_ENABLE - 8];
            quick_cmd_enable_r <= wb1[i2chcb_pkg::CC_QUICK_CMD_ENABLE - 8];            // [RULE11]
         end
         ack_r <= ack_nxt;                                     // [RULE1]
         if (w_bdh && prot_ok) baud_r <= wb0;
         if (w_bdl && prot_ok) baud_low_r <= wb1;
         ien_r   <= ien_nxt;
         mb_r    <= mb_nxt;
         sb_r    <= sb_nxt;
         arb_r   <= arb_nxt;
         hold_r  <= hold_nxt;
         system_op_busy_r <= system_op_busy_nxt;
      end
   end

   // ------------------------------------------------------------------
   // operation request outputs
   // ------------------------------------------------------------------
   logic       op_start_r, op_ack_r, op_apply_r;
   logic [2:0] op_kind_r;

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         op_start_r <= 1'b0;
         op_kind_r  <= i2chcb_pkg::OP_IDLE;
         op_ack_r   <= 1'b0;
         op_apply_r <= 1'b0;
         addr_r     <= 8'h00;
         txd_r      <= 8'h00;
      end else begin
         op_start_r <= release_ev;
         if (release_ev) begin
            op_kind_r  <= kind_nxt;
            op_ack_r   <= ack_nxt;                             // [RULE4]
            op_apply_r <= HOST_READING & ~w_adr & ~w_dat;      // [RULE3]
         end
         if (w_adr) addr_r <= wb0;
         if (w_dat) txd_r <= wb0;
      end
   end

   assign OP_START        = op_start_r;
   assign OP_KIND         = op_kind_r;
   assign OP_ACK_NACK     = op_ack_r;
   assign OP_ACK_APPLY    = op_apply_r;
   assign TX_ADDR         = addr_r;
   assign TX_DATA         = txd_r;
   assign SCL_HOLD        = hold_r;
   assign SCL_HIGH_PERIOD = baud_r;                            // [RULE13]
   assign SCL_LOW_PERIOD  = (baud_low_r != 8'h00) ? baud_low_r
                                                  : baud_r;   // [RULE12]
   assign QUICK_CMD_EN    = quick_cmd_enable_r;
   assign PERIPH_ENABLE   = enable_r;
   assign INT_ENABLE      = ien_r;

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   wire [7:0] rd_a = {ARADDR[7:2], 2'b00};
   assign rd_hit = wr_hit_f(rd_a) | (rd_a == i2chcb_pkg::OFS_STATUS);

   function automatic logic wr_hit_f(input logic [7:0] a);
      wr_hit_f = (a == i2chcb_pkg::OFS_ENABLE)
              | (a == i2chcb_pkg::OFS_CMDCTRL)
              | (a == i2chcb_pkg::OFS_BAUD)
              | (a == i2chcb_pkg::OFS_IENCLR)
              | (a == i2chcb_pkg::OFS_IENSET)
              | (a == i2chcb_pkg::OFS_FLAGS)
              | (a == i2chcb_pkg::OFS_ADDR)
              | (a == i2chcb_pkg::OFS_DATA);
   endfunction

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (rd_a)
         i2chcb_pkg::OFS_ENABLE:  rdata_nxt[i2chcb_pkg::EN_BIT] = enable_r;
         i2chcb_pkg::OFS_CMDCTRL: begin
            // command bits stay zero on read
            rdata_nxt[i2chcb_pkg::CC_ACK]  = ack_r;            // [RULE2]
            rdata_nxt[i2chcb_pkg::CC_QUICK_CMD_ENABLE] = quick_cmd_enable_r;
            rdata_nxt[i2chcb_pkg::CC_AUTO_ACK_ON_READ_ENABLE] = auto_ack_on_read_enable_r;
         end
         i2chcb_pkg::OFS_BAUD:    rdata_nxt[15:0] = {baud_low_r, baud_r};
         i2chcb_pkg::OFS_IENCLR,
         i2chcb_pkg::OFS_IENSET:  rdata_nxt[7:0] = ien_r;      // [RULE15]
         i2chcb_pkg::OFS_FLAGS:   rdata_nxt[1:0] = {sb_r, mb_r};
         i2chcb_pkg::OFS_STATUS:  rdata_nxt[1:0] = {hold_r, system_op_busy_r};
         i2chcb_pkg::OFS_ADDR:    rdata_nxt[7:0] = addr_r;
         i2chcb_pkg::OFS_DATA:    rdata_nxt[7:0] = RX_DATA;
         default:                 rdata_nxt = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   sequence seq_cmd_issue;
      cmd_ok ##1 OP_START;
   endsequence

   chk_cmd_ack_first: assert property (                        // [RULE4]
      cmd_ok |=> OP_ACK_NACK == $past(wr_data_r[i2chcb_pkg::CC_ACK]))
      else $error("command did not use ack select written with it");
   chk_cmd_gate: assert property (                             // [RULE5]
      (w_cch && !flag_any && !w_adr && !w_dat && !smart_rd) |=> !OP_START)
      else $error("command started with no bus flag set");
   chk_cmd_busy: assert property (                             // [RULE8]
      seq_cmd_issue |-> system_op_busy_r)
      else $error("command did not set busy");
   chk_read_nop: assert property (                             // [RULE9]
      (w_cch && cmd_val == i2chcb_pkg::CMD_READ && !HOST_READING)
      |=> !(OP_START && OP_KIND == i2chcb_pkg::OP_ACK_READ))
      else $error("byte read issued while writing");
   chk_smart_ack: assert property (                            // [RULE10]
      smart_rd |=> OP_START ##1 !SCL_HOLD || $past(BYTE_SENT | BYTE_RECEIVED))
      else $error("smart read did not send ack");
   chk_baud_lock: assert property (                            // [RULE17]
      (enable_r && (w_bdh || w_bdl)) |=> $stable(SCL_HIGH_PERIOD)
         && $stable(baud_low_r))
      else $error("baud changed while enabled");
   chk_ien_clear: assert property (                            // [RULE14]
      (w_iec && wb0[i2chcb_pkg::IE_SB] && !w_ies) |=> !INT_ENABLE[1])
      else $error("enable clear did not clear");
   chk_cmd_zero: assert property (                             // [RULE2]
      (rd_fire && rd_a == i2chcb_pkg::OFS_CMDCTRL)
      |=> RDATA[i2chcb_pkg::CC_CMD_HI:i2chcb_pkg::CC_CMD_LO] == 2'b00)
      else $error("command field read non-zero");
   chk_hold_release: assert property (                         // [RULE20]
      (release_ev && !BYTE_SENT && !BYTE_RECEIVED) |=> !SCL_HOLD)
      else $error("clock hold not released");
endmodule // i2chcb_top

// [test/i2chcb_engine_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// bus engine stand-in: byte events on bench control, done after a delay
// ---------------------------------------------------------------------
module i2chcb_engine_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // request from the block
   input  wire logic       op_start,
   // bench controls
   input  wire logic       give_rx,
   input  wire logic       give_tx,
   input  wire logic       slow,
   // events to the block
   output logic            byte_received,
   output logic            byte_sent,
   output logic            op_done,
   output logic [7:0]      rx_data
);
   logic [3:0] wait_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         byte_received <= 1'b0;
         byte_sent     <= 1'b0;
         op_done       <= 1'b0;
         rx_data       <= 8'h00;
         wait_r        <= 4'h0;
      end else begin
         byte_received <= give_rx;
         byte_sent     <= give_tx;
         op_done       <= 1'b0;
         if (give_rx) begin
            rx_data <= rx_data + 8'h3b;
         end
         if (op_start) begin
            wait_r <= slow ? 4'hc : 4'h1;
         end else if (wait_r != 4'h0) begin
            wait_r  <= wait_r - 4'h1;
            op_done <= (wait_r == 4'h1);
         end
      end
   end
endmodule // i2chcb_engine_model

// [test/i2chcb_top_tb.sv]
`timescale 1ns/1ps
module i2chcb_top_tb;
   logic        CLOCK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, OP_START;
   logic        BYTE_RECEIVED, BYTE_SENT, OP_DONE, HOST_READING, SCL_HOLD;
   logic        OP_ACK_NACK, OP_ACK_APPLY, QUICK_CMD_EN, PERIPH_ENABLE;
   logic        give_rx, give_tx, slow, ack_seen, apply_seen;
   logic [7:0]  AWADDR, ARADDR, RX_DATA, TX_ADDR, SCL_HIGH_PERIOD;
   logic [7:0]  SCL_LOW_PERIOD, INT_ENABLE, TX_DATA;
   logic [31:0] WDATA, RDATA, rd;
   logic [3:0]  WSTRB;
   logic [2:0]  OP_KIND, kind_seen;
   logic [1:0]  BRESP, RRESP, rr;
   int          miscompares = 0, compares = 0, ops = 0, rx_n = 0, cyc = 0;

   i2chcb_top u_i2chcb_top (.CLOCK(CLOCK), .RST_N(RST_N),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
      .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
      .RDATA(RDATA), .RRESP(RRESP), .BYTE_RECEIVED(BYTE_RECEIVED),
      .BYTE_SENT(BYTE_SENT), .ARB_LOST(1'b0), .HOST_READING(HOST_READING),
      .OP_DONE(OP_DONE), .RX_DATA(RX_DATA), .OP_START(OP_START),
      .OP_KIND(OP_KIND), .OP_ACK_NACK(OP_ACK_NACK),
      .OP_ACK_APPLY(OP_ACK_APPLY), .TX_ADDR(TX_ADDR), .TX_DATA(TX_DATA),
      .SCL_HOLD(SCL_HOLD), .SCL_HIGH_PERIOD(SCL_HIGH_PERIOD),
      .SCL_LOW_PERIOD(SCL_LOW_PERIOD), .QUICK_CMD_EN(QUICK_CMD_EN),
      .PERIPH_ENABLE(PERIPH_ENABLE), .INT_ENABLE(INT_ENABLE));
   i2chcb_engine_model u_i2chcb_engine_model (.clk(CLOCK), .rst_n(RST_N),
      .op_start(OP_START), .give_rx(give_rx), .give_tx(give_tx),
      .slow(slow), .byte_received(BYTE_RECEIVED), .byte_sent(BYTE_SENT),
      .op_done(OP_DONE), .rx_data(RX_DATA));

   // ------------------------------------------------------------------
   // bus tasks and checking
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge CLOCK);
      AWVALID <= 1'b1; AWADDR <= a; WVALID <= 1'b1; WDATA <= d;
      WSTRB <= s; BREADY <= 1'b1;
      while (aw || w) begin
         @(posedge CLOCK);
         if (aw && AWREADY) begin aw = 1'b0; AWVALID <= 1'b0; end
         if (w && WREADY) begin w = 1'b0; WVALID <= 1'b0; end
      end
      do @(posedge CLOCK); while (BVALID !== 1'b1);
      BREADY <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge CLOCK);
      ARVALID <= 1'b1; ARADDR <= a; RREADY <= 1'b1;
      do @(posedge CLOCK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      do @(posedge CLOCK); while (RVALID !== 1'b1);
      rd = RDATA; rr = RRESP; RREADY <= 1'b0;
   endtask
   task automatic op_chk(input int n0, n_exp, input logic [2:0] k,
                         input logic ak, ap);
      repeat (2) @(posedge CLOCK);
      chk("op count", ops - n0, n_exp);
      if (n_exp == 1) begin
         chk("op kind", kind_seen, k);
         chk("op ack", ack_seen, ak);
         chk("op apply", apply_seen, ap);
      end
   endtask
   task automatic wr_op(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input int n_exp, input logic [2:0] k,
      input logic ak, ap);
      int n0;
      n0 = ops;
      axi_wr(a, d, s);
      op_chk(n0, n_exp, k, ak, ap);
   endtask
   task automatic flag(input logic rd_mode);
      @(posedge CLOCK);
      HOST_READING <= rd_mode; give_rx <= rd_mode; give_tx <= !rd_mode;
      @(posedge CLOCK);
      give_rx <= 1'b0; give_tx <= 1'b0;
      repeat (3) @(posedge CLOCK);
      rx_n += rd_mode;
      chk("scl hold", SCL_HOLD, 1'b1);
   endtask

   always @(posedge CLOCK) begin
      cyc++;
      if (OP_START === 1'b1) begin
         ops++; kind_seen <= OP_KIND; ack_seen <= OP_ACK_NACK;
         apply_seen <= OP_ACK_APPLY;
      end
      if (cyc == 20000) begin miscompares++; report_and_stop(); end
   end
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      axi_rd(i2chcb_pkg::OFS_CMDCTRL); chk("ctrl reset", rd, 32'h0);
      axi_rd(i2chcb_pkg::OFS_BAUD); chk("baud reset", rd, 32'h0);
      axi_rd(i2chcb_pkg::OFS_IENCLR); chk("ien reset", rd, 32'h0);
      axi_rd(8'h30); chk("unmapped", {rd[29:0], rr}, 32'h2);
      axi_wr(i2chcb_pkg::OFS_BAUD, 32'h0000_0012, 4'h3);
      chk("low from baud", SCL_LOW_PERIOD, 8'h12);
      axi_wr(i2chcb_pkg::OFS_BAUD, 32'h0000_3412, 4'h3);
      chk("low field", SCL_LOW_PERIOD, 8'h34);
      chk("high field", SCL_HIGH_PERIOD, 8'h12);
      axi_wr(i2chcb_pkg::OFS_CMDCTRL, 32'h0000_0300, 4'h2);
      chk("quick cmd", QUICK_CMD_EN, 1'b1);
      axi_rd(i2chcb_pkg::OFS_CMDCTRL); chk("ctrl read", rd, 32'h300);
      axi_wr(i2chcb_pkg::OFS_IENSET, 32'h83, 4'h1);
      axi_wr(i2chcb_pkg::OFS_IENCLR, 32'h01, 4'h1);
      axi_wr(i2chcb_pkg::OFS_IENCLR, 32'h00, 4'h1);
      axi_rd(i2chcb_pkg::OFS_IENSET); chk("ien shared", rd, 32'h82);
      axi_wr(i2chcb_pkg::OFS_IENCLR, 32'h82, 4'h1);
      chk("ien cleared", INT_ENABLE, 8'h00);
   endtask
   task automatic t_cmds();
      int n0;
      wr_op(i2chcb_pkg::OFS_CMDCTRL, 32'h0001_0000, 4'h4, 0, 0, 0, 0);
      flag(1'b0);
      wr_op(i2chcb_pkg::OFS_CMDCTRL, 32'h0007_0000, 4'h4, 1,
            i2chcb_pkg::OP_ACK_STOP, 1'b1, 1'b0);
      chk("hold released", SCL_HOLD, 1'b0);
      axi_rd(i2chcb_pkg::OFS_STATUS); chk("busy", rd[0], 1'b1);
      repeat (20) @(posedge CLOCK);
      axi_rd(i2chcb_pkg::OFS_STATUS); chk("idle", rd[0], 1'b0);
      flag(1'b0);
      wr_op(i2chcb_pkg::OFS_CMDCTRL, 32'h0002_0000, 4'h4, 0, 0, 0, 0);
      wr_op(i2chcb_pkg::OFS_ADDR, 32'h5a, 4'h1, 1,
            i2chcb_pkg::OP_NEW_ADDR, 1'b0, 1'b0);
      chk("new address", TX_ADDR, 8'h5a);
      wr_op(i2chcb_pkg::OFS_DATA, 32'hc3, 4'h1, 1,
            i2chcb_pkg::OP_SEND_BYTE, 1'b0, 1'b0);
      chk("tx data", TX_DATA, 8'hc3);
      for (int c = 1; c < 4; c++) begin
         flag(1'b1);
         wr_op(i2chcb_pkg::OFS_CMDCTRL, {13'h0, c[0], c[1:0], 16'h0},
               4'h4, 1, c[2:0], c[0], 1'b1);
         axi_rd(i2chcb_pkg::OFS_CMDCTRL); chk("cmd reads 0", rd[17:16], 0);
      end
      flag(1'b1);
      n0 = ops;
      axi_rd(i2chcb_pkg::OFS_DATA);
      chk("rx data", rd[7:0], 8'(rx_n * 8'h3b));
      op_chk(n0, 1, i2chcb_pkg::OP_ACK_ONLY, 1'b1, 1'b1);
   endtask
   task automatic t_protect();
      slow <= 1'b0;
      axi_wr(i2chcb_pkg::OFS_ENABLE, 32'h2, 4'h1);
      chk("enabled", PERIPH_ENABLE, 1'b1);
      axi_wr(i2chcb_pkg::OFS_BAUD, 32'h0000_0055, 4'h3);
      chk("baud kept", SCL_HIGH_PERIOD, 8'h12);
      axi_wr(i2chcb_pkg::OFS_CMDCTRL, 32'h0, 4'h2);
      chk("quick_cmd_enable kept", QUICK_CMD_EN, 1'b1);
      flag(1'b1);
      wr_op(i2chcb_pkg::OFS_CMDCTRL, 32'h0003_0000, 4'h4, 1,
            i2chcb_pkg::OP_ACK_STOP, 1'b0, 1'b1);
   endtask

   initial begin
      RST_N = 1'b0; AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0;
      ARVALID = 1'b0; RREADY = 1'b0; AWADDR = 8'h00; ARADDR = 8'h00;
      WDATA = 32'h0; WSTRB = 4'h0; HOST_READING = 1'b0;
      give_rx = 1'b0; give_tx = 1'b0; slow = 1'b1;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      t_regs();
      t_cmds();
      t_protect();
      report_and_stop();
   end
endmodule // i2chcb_top_tb
